/* File: design/asr_pkg.sv */
package asr_pkg;

    // result word and counters
    localparam int ASR_WORD_BITS = 16;
    localparam int ASR_CNT_BITS = 5;
    localparam logic [4:0] ASR_CNT_FULL = 5'h10;
    localparam logic [4:0] ASR_CNT_LAST = 5'h0f;
    localparam logic [4:0] ASR_CNT_RST = 5'h00;
    localparam logic [15:0] ASR_SHREG_RST = 16'h0000;

    // serial clock limit the sampler is sized for, and our own sample rate
    localparam int ASR_SCLK_MAX_MHZ = 40;
    localparam int ASR_SYS_MHZ = 250;
    localparam int ASR_SCLK_HALF_CYC = ASR_SYS_MHZ / (2 * ASR_SCLK_MAX_MHZ);

    // pin bundle that passes through the sampler; idle levels after reset
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic rd_n;
        logic chain;
        logic cnv_n;
    } asr_pins_t;

    localparam asr_pins_t ASR_PINS_RST = '{sclk: 1'b0, cs_n: 1'b1, rd_n: 1'b1,
                                          chain: 1'b0, cnv_n: 1'b1};

    // readout progress, gray coded along idle, loaded, shifting, drained
    typedef enum logic [1:0] {
        ASR_IDLE = 2'b00,
        ASR_LOADED = 2'b01,
        ASR_SHIFTING = 2'b11,
        ASR_DRAINED = 2'b10
    } asr_state_t;

endpackage

/* File: design/asr_serial_readout.sv */
`timescale 1ns/100ps
`default_nettype none

module asr_serial_readout
    import asr_pkg::*;
#(
    parameter int WORD_BITS = ASR_WORD_BITS
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // host pins
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic chain_data_in,
    input wire logic convert_start_n_in,
    output logic serial_data_out,
    output logic serial_data_oe_out,
    output logic read_overrun_flag_out,
    // configuration
    input wire logic read_during_conv_in,
    input wire logic chain_enable_in,
    // converter core
    input wire logic busy_in,
    input wire logic [WORD_BITS-1:0] result_in,
    output logic conv_start_out
);

    // pins as they arrive, before any sampling
    asr_pins_t raw_pins;
    // three-stage sampler, filtered level and its one-clock delay
    asr_pins_t sync1_ff, sync2_ff, sync3_ff, flt_ff, flt_d_ff;
    asr_pins_t nxt_flt;
    // busy from the core is on our clock, one delay finds its fall
    logic busy_d_ff;
    // result shifter, bit counter and readout progress
    logic [WORD_BITS-1:0] shreg_ff, nxt_shreg;
    logic [ASR_CNT_BITS-1:0] cnt_ff, nxt_cnt;
    asr_state_t state_ff, nxt_state;
    // chain bit held between the sampling edge and the shift edge
    logic chain_bit_ff, nxt_chain_bit;
    // registered pin drivers, so the outputs carry no decode glitches
    logic sdo_ff, nxt_sdo;
    logic oe_ff, nxt_oe;
    logic ovr_ff, nxt_ovr;
    logic cstart_ff, nxt_cstart;
    // decoded select and mode levels, and edge strobes each one system clock wide
    logic active, sclk_rise, sclk_fall, busy_fall, may_shift;

    // a level counts once the second and third stage agree, else keep the old one
    function automatic asr_pins_t agree(input asr_pins_t a, input asr_pins_t b,
                                        input asr_pins_t old);
        agree = (a & b) | (old & (a | b));
    endfunction

    // one bundle, so every pin sees the same sampler latency
    assign raw_pins = '{sclk: sclk_in, cs_n: cs_n_in, rd_n: rd_n_in,
                        chain: chain_data_in, cnv_n: convert_start_n_in};

    // pin sampler; first stage feeds only the second
    // the agreement step costs a clock of latency but rejects a one-clock
    // glitch on a slow host edge, which would otherwise shift a bit twice
    always_comb begin
        nxt_flt = agree(sync2_ff, sync3_ff, flt_ff);
    end

    // reset values match the idle pins, so no false edge follows reset
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync1_ff <= ASR_PINS_RST;
            sync2_ff <= ASR_PINS_RST;
            sync3_ff <= ASR_PINS_RST;
            flt_ff <= ASR_PINS_RST;
            flt_d_ff <= ASR_PINS_RST;
            busy_d_ff <= 1'b0;
        end else begin
            sync1_ff <= raw_pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            flt_ff <= nxt_flt;
            flt_d_ff <= flt_ff;
            busy_d_ff <= busy_in;
        end
    end

    // the sampler needs about three system clocks per serial clock phase,
    // which a 40 mhz serial clock just meets at 250 mhz
    assign active = ~flt_ff.cs_n & ~flt_ff.rd_n;
    assign sclk_rise = active & flt_ff.sclk & ~flt_d_ff.sclk;
    assign sclk_fall = active & ~flt_ff.sclk & flt_d_ff.sclk;
    // core busy is already on our clock, so it skips the sampler
    assign busy_fall = busy_d_ff & ~busy_in;
    // the mode is a same-clock level; changing it mid-read is not supported,
    // the next busy fall brings the engine back to a known word
    // after-conversion reads wait for busy low; conversion reads run while busy
    assign may_shift = read_during_conv_in | ~busy_in;

    // readout engine
    // a busy fall wins over a shift edge in the same cycle: the fresh
    // result must not lose its msb to a stale serial clock edge
    // the counter saturates at the word length so a long chained read cannot
    // wrap it back into the shifting state and fake an overrun
    always_comb begin
        nxt_shreg = shreg_ff;
        nxt_cnt = cnt_ff;
        nxt_state = state_ff;
        nxt_chain_bit = chain_bit_ff;
        nxt_ovr = 1'b0;
        if (busy_fall) begin
            // a read during conversion still shifting when the conversion ends is flagged
            nxt_ovr = read_during_conv_in && (state_ff == ASR_SHIFTING);
            nxt_shreg = result_in;
            // a read cut here starts again at the msb of the new word
            nxt_cnt = ASR_CNT_RST;
            nxt_state = ASR_LOADED;
        end else if (may_shift && state_ff != ASR_IDLE) begin
            if (sclk_rise) begin
                // chain bit caught on the edge opposite the shift edge
                nxt_chain_bit = chain_enable_in & ~read_during_conv_in
                                & flt_ff.chain;
            end
            if (sclk_fall) begin
                // chain bits enter behind our lsb, so they follow at once
                nxt_shreg = {shreg_ff[WORD_BITS-2:0], chain_bit_ff};
                // stop counting once the whole word has left
                if (cnt_ff != ASR_CNT_FULL) begin
                    nxt_cnt = cnt_ff + 5'h01;
                end
                if (cnt_ff >= ASR_CNT_LAST) begin
                    nxt_state = ASR_DRAINED;
                end else begin
                    nxt_state = ASR_SHIFTING;
                end
            end
        end
    end

    // output pin: msb of the shifter while selected, low when nothing to send
    // once drained only chain bits may reach the pin; without a chain the
    // line idles low, so a long read clocks in zeros
    always_comb begin
        nxt_oe = active;
        nxt_sdo = 1'b0;
        unique case (state_ff)
            ASR_IDLE: begin
                // nothing loaded since reset
                nxt_sdo = 1'b0;
            end
            ASR_LOADED, ASR_SHIFTING: begin
                nxt_sdo = active & shreg_ff[WORD_BITS-1];
            end
            ASR_DRAINED: begin
                nxt_sdo = active & chain_enable_in & ~read_during_conv_in
                          & shreg_ff[WORD_BITS-1];
            end
        endcase
    end

    // convert start: one pulse per filtered falling edge; a start line held
    // low does not retrigger, the core sees one request per edge
    always_comb begin
        nxt_cstart = flt_d_ff.cnv_n & ~flt_ff.cnv_n;
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cstart_ff <= 1'b0;
        end else begin
            cstart_ff <= nxt_cstart;
        end
    end

    // readout and pin registers; reset leaves nothing readable

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shreg_ff <= ASR_SHREG_RST;
            cnt_ff <= ASR_CNT_RST;
            state_ff <= ASR_IDLE;
            chain_bit_ff <= 1'b0;
            ovr_ff <= 1'b0;
            sdo_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            shreg_ff <= nxt_shreg;
            cnt_ff <= nxt_cnt;
            state_ff <= nxt_state;
            chain_bit_ff <= nxt_chain_bit;
            ovr_ff <= nxt_ovr;
            sdo_ff <= nxt_sdo;
            oe_ff <= nxt_oe;
        end
    end

    // every output comes straight from a flop; the enable and the data
    // switch in the same cycle, so a deselect never shows a stray bit
    // limitation: the data output idles low rather than floating, the pad
    // ring must use the enable to release the line
    assign serial_data_out = sdo_ff;
    assign serial_data_oe_out = oe_ff;
    assign read_overrun_flag_out = ovr_ff;
    assign conv_start_out = cstart_ff;

endmodule

`default_nettype wire

/* File: verification/asr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// host serial port as master; clock idles low and runs only inside frames
// the host keeps the clock source select high, so the clock comes from here
module asr_host_model (
    input wire logic clk_sys_in,
    input wire logic serial_data_in,
    output logic sclk_out, output logic cs_n_out, output logic rd_n_out,
    output logic chain_out, output logic cnv_n_out
);
    initial {sclk_out, cs_n_out, rd_n_out, chain_out, cnv_n_out} = 5'h0d;
    // one convert start line, shared by every cascaded device
    task automatic cnv();
        cnv_n_out <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        cnv_n_out <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
    endtask
    // 32 ns period; sampled late in the high phase, after the last shift has settled
    // about 31 mhz meets the low-power and normal conversion read minimums
    task automatic rd(input bit sel, input int n, input logic [15:0] up, output logic [31:0] got);
        logic [15:0] c;
        c = up;
        got = 32'h0;
        {cs_n_out, rd_n_out} <= {!sel, 1'b0};
        chain_out <= c[15];
        repeat (8) @(posedge clk_sys_in);
        for (int i = 0; i < n; i++) begin
            sclk_out <= 1'b1;
            repeat (4) @(posedge clk_sys_in);
            got = {got[30:0], serial_data_in};
            sclk_out <= 1'b0;
            c = c << 1;
            chain_out <= c[15];
            repeat (4) @(posedge clk_sys_in);
        end
        {cs_n_out, rd_n_out} <= 2'h3;
        repeat (8) @(posedge clk_sys_in);
    endtask
endmodule
`default_nettype wire

/* File: verification/asr_serial_readout_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// pin-level checks; sampler latency is at most five clocks, so eight settled cycles suffice
module asr_readout_chk (
    input wire logic clk_sys_in, input wire logic reset_n_in, input wire logic cs_n_in,
    input wire logic rd_n_in, input wire logic busy_in, input wire logic read_during_conv_in,
    input wire logic serial_data_out, input wire logic serial_data_oe_out,
    input wire logic read_overrun_flag_out, input wire logic conv_start_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    AST_CS_OFF: assert property (cs_n_in [*8] |-> !serial_data_oe_out)
        else $error("oe on while chip select high");
    AST_RD_OFF: assert property (rd_n_in [*8] |-> !serial_data_oe_out)
        else $error("oe on while read enable high");
    AST_SEL_ON: assert property ((!cs_n_in && !rd_n_in) [*8] |-> serial_data_oe_out)
        else $error("oe off while selected");
    AST_IDLE_ZERO: assert property (!serial_data_oe_out |-> !serial_data_out)
        else $error("data not idle while undriven");
    AST_OVR_PULSE: assert property (read_overrun_flag_out |=> !read_overrun_flag_out)
        else $error("overrun longer than one cycle");
    AST_OVR_CAUSE: assert property (
        read_overrun_flag_out |-> $past(busy_in, 2) && !$past(busy_in))
        else $error("overrun without end of conversion");
    AST_OVR_MODE: assert property (!read_during_conv_in [*2] |-> !read_overrun_flag_out)
        else $error("overrun in read after mode");
    // shifting is frozen while a conversion runs in read after mode
    AST_HOLD_BUSY: assert property (
        (busy_in && !read_during_conv_in && serial_data_oe_out) [*8]
        |-> $stable(serial_data_out)) else $error("data moved during busy");
    cover property (read_overrun_flag_out);
    cover property (conv_start_out);
    cover property (serial_data_oe_out && serial_data_out);
endmodule
bind asr_serial_readout asr_readout_chk u_chk (.clk_sys_in, .reset_n_in, .cs_n_in, .rd_n_in,
    .busy_in, .read_during_conv_in, .serial_data_out, .serial_data_oe_out,
    .read_overrun_flag_out, .conv_start_out);
`default_nettype wire

/* File: verification/asr_serial_readout_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module asr_serial_readout_tb_top;
    typedef struct packed {logic rdc; logic [15:0] r; logic [15:0] up; int n;
        logic [31:0] e;} asr_row_t;
    asr_row_t rows [4] = '{'{1'b0, 16'ha5c3, 16'h0, 20, 32'h000a5c30},
        '{1'b0, 16'h8001, 16'h7ffe, 32, 32'h80017ffe}, '{1'b0, 16'hffff, 16'h0, 17, 32'h0001fffe},
        '{1'b1, 16'h3c5a, 16'h0, 16, 32'h00003c5a}};
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic busy_in = 1'b0;
    logic rdc = 1'b0;
    logic chain_en = 1'b0;
    logic [15:0] result_in = 16'h0;
    logic [31:0] got;
    wire logic sclk, cs_n, rd_n, chain, cnv_n, sdo, oe, ovr, cst;
    int fails = 0;
    int checks = 0;
    int povr = 0;
    int pcst = 0;
    int ncnv = 0;
    logic held = 1'b0;
    wire logic line;
    // a released data line shows the opposite of its last driven bit
    always @(posedge clk_sys_in) begin
        if (oe === 1'b1)
            held <= sdo;
    end
    assign line = (oe === 1'b1) ? sdo : ~held;
    always #2 clk_sys_in = ~clk_sys_in;
    // count one-cycle pulses from the design
    always @(posedge clk_sys_in) begin
        povr += (ovr === 1'b1);
        pcst += (cst === 1'b1);
    end
    asr_serial_readout dut (.clk_sys_in, .reset_n_in, .sclk_in(sclk), .cs_n_in(cs_n),
        .rd_n_in(rd_n), .chain_data_in(chain), .convert_start_n_in(cnv_n), .serial_data_out(sdo),
        .serial_data_oe_out(oe), .read_overrun_flag_out(ovr), .read_during_conv_in(rdc),
        .chain_enable_in(chain_en), .busy_in, .result_in, .conv_start_out(cst));
    asr_host_model host (.clk_sys_in, .serial_data_in(line), .sclk_out(sclk), .cs_n_out(cs_n),
        .rd_n_out(rd_n), .chain_out(chain), .cnv_n_out(cnv_n));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // start, then stand in for the core: busy pulse ending with a fresh result
    task automatic conv(input logic [15:0] r);
        host.cnv();
        {busy_in, result_in} <= {1'b1, r};
        ncnv++;
        repeat (12) @(posedge clk_sys_in);
        busy_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    task automatic final_report();
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        check("reset", {oe, sdo, ovr, cst}, 32'h0);
        host.rd(1'b1, 16, 16'h0, got);
        check("empty", got, 32'h0);
        foreach (rows[i]) begin
            {rdc, chain_en} <= {rows[i].rdc, |rows[i].up};
            conv(rows[i].r);
            busy_in <= rows[i].rdc;
            host.rd(1'b1, rows[i].n, rows[i].up, got);
            busy_in <= 1'b0;
            check("row", got, rows[i].e);
        end
        check("no overrun", povr, 0);
        // read during conversion abandoned after five bits, then a clean one
        conv(16'hc3a5);
        busy_in <= 1'b1;
        host.rd(1'b1, 5, 16'h0, got);
        busy_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        check("overrun", povr, 1);
        check("partial", got, 32'h18);
        busy_in <= 1'b1;
        host.rd(1'b1, 16, 16'h0, got);
        busy_in <= 1'b0;
        check("restart", got, 32'hc3a5);
        // read begun after a conversion, finished after the next one starts
        conv(16'h5aa5);
        fork
            host.rd(1'b1, 16, 16'h0, got);
            begin
                repeat (60) @(posedge clk_sys_in);
                busy_in <= 1'b1;
            end
        join
        busy_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        check("split", got, 32'h5aa5);
        check("split no overrun", povr, 1);
        // read after mode: clocks during busy and while deselected leave the word alone
        rdc <= 1'b0;
        conv(16'h8421);
        busy_in <= 1'b1;
        host.rd(1'b1, 4, 16'h0, got);
        check("busy hold", got, 32'hf);
        busy_in <= 1'b0;
        host.rd(1'b0, 8, 16'h0, got);
        check("deselected", got, 32'h0);
        host.rd(1'b1, 16, 16'h0, got);
        check("held word", got, 32'h8421);
        check("starts", pcst, ncnv);
        final_report();
    end
    // the sequence needs about 1700 clocks
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        fails++;
        final_report();
    end
endmodule
`default_nettype wire
